// ==== rtl/fadiag_top.v ====
// Behaviour
// - retry request per output on overcurrent, overheat or undervoltage
// - autoretry only acts while in fault mode
// - retry after one autoretry period, at most sixteen attempts per output
// - retry counters cleared on mode change or retry-disable toggle
// - each retry restores default inrush overcurrent profile before turn-on
// - short to supply latches short and off open-load flags, fault pin live
// - short detect disable bit suppresses short detection
// - off open-load latched while off, cleared by read once gone
// - off open-load disable bit suppresses off open-load detection
// - led select bit picks led or bulb on-state threshold
// - on-state open load sets flag only, output and fault pin untouched
// - led mode samples once per period, fully on, on for one period
// - on-state flag held until condition gone and status read
// - on open-load disable bit suppresses on-state detection
// - sense output routes current copy of chosen output or temperature
// - current copy only during on time, never in fail-safe
// - temperature prewarning latched in normal mode, cleared by read
// - supply clamp cancels protective turn-off and forces all outputs on
// - logic supply loss or enabled failure resets all configuration
// - without logic supply direct inputs drive outputs, config read as zero
// - battery loss with wake high keeps config, reports undervoltage
// - both supplies below power-on level clear registers and faults
// - latched protection bits cleared after a status read
`timescale 1ns/1ps
`include "fadiag_defines.vh"

module fadiag_top #(
  parameter T_AUTO_CYC = `FAD_T_AUTO_CYC,
  parameter LED_OPENLOAD_PERIOD_CYC = `FAD_LED_OPENLOAD_PERIOD_CYC
) (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  // supplies and modes
  input wire logic_supply_ok,
  input wire logic_supply_fail,
  input wire supply_fail_enable,
  input wire battery_ok,
  input wire wake_reset_pin,
  input wire por_both_low,
  input wire fail_safe_mode,
  input wire clamp_active,
  // per-output commands and analog comparators
  input wire [3:0] output_command,
  input wire [3:0] direct_inputs,
  input wire [27:0] duty_fields,
  input wire [3:0] overcurrent_det,
  input wire [3:0] overtemp_det,
  input wire [3:0] gate_low,
  input wire [3:0] short_det,
  input wire [3:0] off_openload_det,
  input wire [3:0] on_low_current_bulb,
  input wire [3:0] on_low_current_led,
  input wire temp_warning_det,
  // configuration writes
  input wire cfg_write,
  input wire [3:0] cfg_retry_disable,
  input wire [3:0] cfg_short_detect_disable,
  input wire [3:0] cfg_off_openload_disable,
  input wire [3:0] cfg_on_openload_disable,
  input wire [3:0] cfg_led_threshold_select,
  input wire [3:0] cfg_sense_ratio_select,
  input wire cfg_temp_enable,
  input wire cfg_sense_enable,
  input wire [1:0] cfg_sense_output_select,
  // status read strobe
  input wire status_read,
  // outputs
  output reg [3:0] switch_outputs,
  output wire fault_status_pin_n,
  output reg [3:0] overcurrent_fault,
  output reg [3:0] overtemp_fault,
  output reg undervoltage_fault,
  output reg [3:0] short_to_supply_flag,
  output reg [3:0] off_open_load_flag,
  output reg [3:0] on_load_missing_flag,
  output reg temp_prewarning_flag,
  output reg [3:0] default_inrush_profile,
  output reg [3:0] retry_exhausted,
  output reg [2:0] sense_route,
  output reg [1:0] sense_channel,
  output reg sense_ratio_high
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;
  // last cycle of each period, cut to the timer width
  localparam integer AUTO_LAST_I = T_AUTO_CYC - 1;
  localparam integer LED_THRESHOLD_SELECT_LAST_I = LED_OPENLOAD_PERIOD_CYC - 1;
  localparam [22:0] AUTO_LAST = AUTO_LAST_I[22:0];
  localparam [22:0] LED_THRESHOLD_SELECT_LAST = LED_THRESHOLD_SELECT_LAST_I[22:0];

  //////////////////////////////////////////////////////////////////////////
  // configuration
  reg [3:0] retry_dis_reg;
  reg [3:0] short_dis_reg;
  reg [3:0] offol_dis_reg;
  reg [3:0] onol_dis_reg;
  reg [3:0] led_sel_reg;
  reg [3:0] ratio_reg;
  reg temp_en_reg;
  reg sense_en_reg;
  reg [1:0] sense_sel_reg;
  reg fail_safe_reg;
  reg [3:0] cmd_reg;
  wire cfg_wipe = !logic_supply_ok || por_both_low ||
    (logic_supply_fail && supply_fail_enable);
  wire [3:0] retry_dis_toggle = cfg_write ?
    (retry_dis_reg ^ cfg_retry_disable) : 4'h0;
  wire mode_change = fail_safe_reg ^ fail_safe_mode;
  wire [3:0] cmd_now = logic_supply_ok ? output_command :
    direct_inputs;
  wire [3:0] cmd_rise = cmd_now & ~cmd_reg;
  wire [3:0] cmd_fall = ~cmd_now & cmd_reg;
  wire uv_now = !battery_ok;
  wire fault_mode = |(overcurrent_fault | overtemp_fault) ||
    undervoltage_fault;

  // configuration registers, wiped on logic supply loss

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      retry_dis_reg <= 4'h0;
      short_dis_reg <= 4'h0;
      offol_dis_reg <= 4'h0;
      onol_dis_reg <= 4'h0;
      led_sel_reg <= 4'h0;
      ratio_reg <= 4'h0;
      temp_en_reg <= 1'b0;
      sense_en_reg <= 1'b0;
      sense_sel_reg <= 2'h0;
      fail_safe_reg <= 1'b0;
      cmd_reg <= 4'h0;
    end else if (clk_en) begin
      fail_safe_reg <= fail_safe_mode;
      cmd_reg <= cmd_now;
      if (cfg_wipe) begin
        retry_dis_reg <= 4'h0;
        short_dis_reg <= 4'h0;
        offol_dis_reg <= 4'h0;
        onol_dis_reg <= 4'h0;
        led_sel_reg <= 4'h0;
        ratio_reg <= 4'h0;
        temp_en_reg <= 1'b0;
        sense_en_reg <= 1'b0;
        sense_sel_reg <= 2'h0;
      end else if (cfg_write) begin
        retry_dis_reg <= cfg_retry_disable;
        short_dis_reg <= cfg_short_detect_disable;
        offol_dis_reg <= cfg_off_openload_disable;
        onol_dis_reg <= cfg_on_openload_disable;
        led_sel_reg <= cfg_led_threshold_select;
        ratio_reg <= cfg_sense_ratio_select;
        temp_en_reg <= cfg_temp_enable;
        sense_en_reg <= cfg_sense_enable;
        sense_sel_reg <= cfg_sense_output_select;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // protection faults and autoretry, per output
  wire fault_wipe = por_both_low ||
    (logic_supply_fail && supply_fail_enable && battery_ok);
  reg [1:0] rstate [0:3];
  reg [22:0] rtimer [0:3];
  reg [4:0] rcount [0:3];
  reg [3:0] retry_pulse;
  reg [3:0] latched_off;
  reg [3:0] led_threshold_select_ok;
  reg [22:0] on_timer [0:3];
  reg [22:0] led_threshold_select_timer;
  wire led_threshold_select_tick = (led_threshold_select_timer == LED_THRESHOLD_SELECT_LAST);
  wire [3:0] retry_req = overcurrent_fault | overtemp_fault |
    {4{undervoltage_fault}};
  integer i;

  // free-running led open-load sampling period

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      led_threshold_select_timer <= 23'h00_0000;
    end else if (clk_en) begin
      led_threshold_select_timer <= led_threshold_select_tick ? 23'h00_0000 : led_threshold_select_timer + 23'h00_0001;
    end
  end

  // per-output fault latches and retry state

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        rstate[i] <= ST_IDLE;
        rtimer[i] <= 23'h00_0000;
        rcount[i] <= 5'h00;
        on_timer[i] <= 23'h00_0000;
      end
      overcurrent_fault <= 4'h0;
      overtemp_fault <= 4'h0;
      undervoltage_fault <= 1'b0;
      latched_off <= 4'h0;
      retry_pulse <= 4'h0;
      default_inrush_profile <= 4'h0;
      retry_exhausted <= 4'h0;
      short_to_supply_flag <= 4'h0;
      off_open_load_flag <= 4'h0;
      on_load_missing_flag <= 4'h0;
      temp_prewarning_flag <= 1'b0;
      led_threshold_select_ok <= 4'h0;
    end else if (clk_en) begin
      if (fault_wipe) begin
        overcurrent_fault <= 4'h0;
        overtemp_fault <= 4'h0;
        undervoltage_fault <= 1'b0;
        short_to_supply_flag <= 4'h0;
        off_open_load_flag <= 4'h0;
        on_load_missing_flag <= 4'h0;
        temp_prewarning_flag <= 1'b0;
        latched_off <= 4'h0;
      end else begin
        // set wins over read clear
        if (uv_now)
          undervoltage_fault <= 1'b1;
        else if (status_read)
          undervoltage_fault <= 1'b0;
        if (!fail_safe_mode && temp_warning_det)
          temp_prewarning_flag <= 1'b1;
        else if (status_read)
          temp_prewarning_flag <= 1'b0;
        for (i = 0; i < 4; i = i + 1) begin
          if (overcurrent_det[i] && switch_outputs[i])
            overcurrent_fault[i] <= 1'b1;
          else if (status_read)
            overcurrent_fault[i] <= 1'b0;
          if (overtemp_det[i])
            overtemp_fault[i] <= 1'b1;
          else if (status_read)
            overtemp_fault[i] <= 1'b0;
          if ((overcurrent_det[i] && switch_outputs[i]) ||
              (overtemp_det[i] && cmd_now[i]) || (uv_now && cmd_now[i]))
            latched_off[i] <= 1'b1;
          else if (cmd_fall[i] || retry_pulse[i])
            latched_off[i] <= 1'b0;
          if (!cmd_now[i] && gate_low[i] && short_det[i] &&
              !short_dis_reg[i]) begin
            short_to_supply_flag[i] <= 1'b1;
            off_open_load_flag[i] <= 1'b1;
          end else begin
            if (status_read)
              short_to_supply_flag[i] <= 1'b0;
            if (!cmd_now[i] && gate_low[i] && off_openload_det[i] &&
                !offol_dis_reg[i])
              off_open_load_flag[i] <= 1'b1;
            else if (status_read)
              off_open_load_flag[i] <= 1'b0;
          end
          // on-state open load: bulb is continuous, led is periodic
          on_timer[i] <= !switch_outputs[i] ? 23'h00_0000 :
            (on_timer[i] == LED_THRESHOLD_SELECT_LAST) ? on_timer[i] :
            on_timer[i] + 23'h00_0001;
          led_threshold_select_ok[i] <= switch_outputs[i] &&
            (duty_fields[i*7 +: 7] == `FAD_DUTY_FULL) &&
            (on_timer[i] == LED_THRESHOLD_SELECT_LAST);
          if (switch_outputs[i] && !onol_dis_reg[i] && (led_sel_reg[i] ?
              (led_threshold_select_tick && led_threshold_select_ok[i] && on_low_current_led[i]) :
              on_low_current_bulb[i]))
            on_load_missing_flag[i] <= 1'b1;
          else if (status_read)
            on_load_missing_flag[i] <= 1'b0;
          // autoretry
          retry_pulse[i] <= 1'b0;
          default_inrush_profile[i] <= cmd_rise[i];
          if (mode_change || retry_dis_toggle[i]) begin
            rcount[i] <= 5'h00;
            retry_exhausted[i] <= 1'b0;
            rstate[i] <= ST_IDLE;
          end else begin
            case (rstate[i])
              ST_IDLE: begin
                rtimer[i] <= 23'h00_0000;
                // skip the edge where latched_off has not yet cleared
                if (fault_mode && retry_req[i] && latched_off[i] &&
                    !retry_pulse[i] && !retry_dis_reg[i] && cmd_now[i] &&
                    (rcount[i] != `FAD_RETRY_MAX))
                  rstate[i] <= ST_WAIT;
                retry_exhausted[i] <= (rcount[i] == `FAD_RETRY_MAX);
              end
              ST_WAIT: begin
                rtimer[i] <= rtimer[i] + 23'h00_0001;
                if (!cmd_now[i] || !fault_mode)
                  rstate[i] <= ST_IDLE;
                else if (rtimer[i] == AUTO_LAST) begin
                  retry_pulse[i] <= 1'b1;
                  default_inrush_profile[i] <= 1'b1;
                  rcount[i] <= rcount[i] + 5'h01;
                  rstate[i] <= ST_IDLE;
                end
              end
              default: rstate[i] <= ST_IDLE;
            endcase
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs, fault pin and sense routing
  wire [3:0] live_off_fault = ~cmd_now & (overtemp_det |
    (short_det & ~short_dis_reg));
  assign fault_status_pin_n = !(|latched_off || |live_off_fault || uv_now);

  // switch drive and sense routing

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      switch_outputs <= 4'h0;
      sense_route <= `FAD_SNS_OFF;
      sense_channel <= 2'h0;
      sense_ratio_high <= 1'b0;
    end else if (clk_en) begin
      if (clamp_active)
        switch_outputs <= 4'hf;
      else
        switch_outputs <= cmd_now & ~latched_off & ~retry_pulse &
          {4{battery_ok}};
      sense_channel <= sense_sel_reg;
      sense_ratio_high <= ratio_reg[sense_sel_reg];
      if (temp_en_reg)
        sense_route <= `FAD_SNS_TEMP;
      else if (sense_en_reg && !fail_safe_mode &&
               switch_outputs[sense_sel_reg])
        sense_route <= `FAD_SNS_CUR;
      else
        sense_route <= `FAD_SNS_OFF;
    end
  end

endmodule // fadiag_top

// ==== rtl/fadiag_defines.vh ====
`ifndef FADIAG_DEFINES_VH
`define FADIAG_DEFINES_VH
`define FAD_NCH 4
`define FAD_RETRY_MAX 5'h10
`define FAD_CLK_MHZ 40
`define FAD_T_AUTO_US 150
`define FAD_T_AUTO_CYC (`FAD_T_AUTO_US * `FAD_CLK_MHZ)
`define FAD_LED_OPENLOAD_PERIOD_US 1000
`define FAD_LED_OPENLOAD_PERIOD_CYC (`FAD_LED_OPENLOAD_PERIOD_US * `FAD_CLK_MHZ)
`define FAD_DUTY_FULL 7'h7f
`define FAD_SNS_TEMP 3'b001
`define FAD_SNS_CUR 3'b010
`define FAD_SNS_OFF 3'b100
`endif

// ==== verif/fad_host.sv ====
`timescale 1ns/1ps
// host side: registers bench requests into strobes one cycle later, as long as the request
module fad_host (
  // clock
  input wire clk_sys,
  // requests from the bench
  input wire rd_req,
  input wire wr_req,
  // strobes to the block
  output reg status_read,
  output reg cfg_write
);
  initial status_read = 1'b0;
  initial cfg_write = 1'b0;
  always @(posedge clk_sys) begin
    status_read <= rd_req;
    cfg_write <= wr_req;
  end
endmodule // fad_host

// ==== verif/fad_checker.sv ====
`timescale 1ns/1ps
module fad_checker #(
  parameter T_AUTO_CYC = 6000,
  parameter LED_OPENLOAD_PERIOD_CYC = 40000
) (
  // clock, reset, supplies
  input wire clk_sys,
  input wire rst,
  input wire clk_en,
  input wire por_both_low,
  input wire logic_supply_ok,
  input wire logic_supply_fail,
  input wire fail_safe_mode,
  input wire clamp_active,
  input wire temp_warning_det,
  input wire status_read,
  input wire [3:0] output_command,
  input wire [3:0] direct_inputs,
  input wire [3:0] short_det,
  // watched outputs
  input wire [3:0] switch_outputs,
  input wire [3:0] short_to_supply_flag,
  input wire [3:0] off_open_load_flag,
  input wire [3:0] on_load_missing_flag,
  input wire [3:0] overcurrent_fault,
  input wire [3:0] default_inrush_profile,
  input wire temp_prewarning_flag,
  input wire [2:0] sense_route
);
  wire wipe = por_both_low | ~logic_supply_ok | logic_supply_fail;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_clamp;
    clamp_active && clk_en;
  endsequence
  sequence s_por;
    por_both_low && clk_en;
  endsequence
  a_short_cause: assert property ((short_to_supply_flag &
    ~$past(short_to_supply_flag) & ~$past(short_det)) == 4'h0)
    else $error("short flag set without short");
  a_short_pair: assert property ((short_to_supply_flag &
    ~$past(short_to_supply_flag) & ~off_open_load_flag) == 4'h0)
    else $error("short flag without off open-load flag");
  a_clamp_on: assert property (s_clamp |=> switch_outputs == 4'hf)
    else $error("clamp did not force outputs on");
  a_inrush_cmd: assert property (
    (default_inrush_profile &
    ~$past(logic_supply_ok ? output_command : direct_inputs)) == 4'h0)
    else $error("inrush profile with output not commanded");
  a_por_clear: assert property (s_por |=> overcurrent_fault == 4'h0 &&
    short_to_supply_flag == 4'h0 && !temp_prewarning_flag)
    else $error("flags survive power-on reset");
  a_sense_fs: assert property (
    fail_safe_mode && $past(fail_safe_mode) |-> !sense_route[1])
    else $error("current copy routed in fail-safe");
  a_warn_cause: assert property ($rose(temp_prewarning_flag) |->
    $past(temp_warning_det) && !$past(fail_safe_mode))
    else $error("prewarning set without cause");
  a_on_load_missing_flag_quiet: assert property ((on_load_missing_flag &
    ~$past(on_load_missing_flag) & ~switch_outputs) == 4'h0)
    else $error("output dropped with on-state open load");
  a_on_load_missing_flag_hold: assert property ((~on_load_missing_flag &
    $past(on_load_missing_flag)) != 4'h0 |-> $past(status_read | wipe))
    else $error("on-state flag cleared without read");
endmodule // fad_checker
bind fadiag_top fad_checker #(.T_AUTO_CYC(T_AUTO_CYC),
  .LED_OPENLOAD_PERIOD_CYC(LED_OPENLOAD_PERIOD_CYC)) i_fad_checker (.clk_sys, .rst, .clk_en,
  .por_both_low, .logic_supply_ok, .logic_supply_fail, .fail_safe_mode,
  .clamp_active, .temp_warning_det, .status_read, .output_command,
  .direct_inputs, .short_det, .switch_outputs, .short_to_supply_flag,
  .off_open_load_flag,
  .on_load_missing_flag, .overcurrent_fault, .default_inrush_profile,
  .temp_prewarning_flag, .sense_route);

// ==== verif/test_fault_autoretry_diagnostics.sv ====
`timescale 1ns/1ps
module test_fault_autoretry_diagnostics;
  reg clk_sys = 1'b0, rst = 1'b1, clk_en = 1'b1, logic_supply_ok = 1'b1;
  reg logic_supply_fail = 1'b0, supply_fail_enable = 1'b0, battery_ok = 1'b1;
  reg wake_reset_pin = 1'b1, por_both_low = 1'b0, fail_safe_mode = 1'b0;
  reg clamp_active = 1'b0, temp_warning_det = 1'b0, rd_req = 1'b0;
  reg wr_req = 1'b0, cfg_temp_enable = 1'b0, cfg_sense_enable = 1'b0;
  reg [1:0] cfg_sense_output_select = 2'h0;
  reg [27:0] duty_fields = 28'h000_0000;
  reg [3:0] output_command = 4'h0, direct_inputs = 4'h0, short_det = 4'h0;
  reg [3:0] overcurrent_det = 4'h0, overtemp_det = 4'h0, gate_low = 4'h0;
  reg [3:0] off_openload_det = 4'h0, on_low_current_bulb = 4'h0;
  reg [3:0] on_low_current_led = 4'h0, cfg_retry_disable = 4'h0;
  reg [3:0] cfg_short_detect_disable = 4'h0, cfg_off_openload_disable = 4'h0;
  reg [3:0] cfg_on_openload_disable = 4'h0, cfg_led_threshold_select = 4'h0;
  reg [3:0] cfg_sense_ratio_select = 4'h0;
  wire status_read, cfg_write, fault_status_pin_n, undervoltage_fault;
  wire temp_prewarning_flag, sense_ratio_high;
  wire [3:0] switch_outputs, overcurrent_fault, overtemp_fault;
  wire [3:0] retry_exhausted;
  wire [3:0] short_to_supply_flag, off_open_load_flag, on_load_missing_flag;
  wire [3:0] default_inrush_profile;
  wire [2:0] sense_route;
  wire [1:0] sense_channel;
  integer bad_count = 0, checks_done = 0, k, seen;
  always #12.5 clk_sys = ~clk_sys;
  fad_host i_fad_host (.clk_sys, .rd_req, .wr_req, .status_read, .cfg_write);
  fadiag_top #(.T_AUTO_CYC(20), .LED_OPENLOAD_PERIOD_CYC(30)) i_fadiag_top (.clk_sys,
    .rst, .clk_en, .logic_supply_ok, .logic_supply_fail, .supply_fail_enable,
    .battery_ok, .wake_reset_pin, .por_both_low, .fail_safe_mode,
    .clamp_active, .output_command, .direct_inputs, .duty_fields,
    .overcurrent_det, .overtemp_det, .gate_low, .short_det, .off_openload_det,
    .on_low_current_bulb, .on_low_current_led, .temp_warning_det, .cfg_write,
    .cfg_retry_disable, .cfg_short_detect_disable, .cfg_off_openload_disable,
    .cfg_on_openload_disable, .cfg_led_threshold_select,
    .cfg_sense_ratio_select, .cfg_temp_enable, .cfg_sense_enable,
    .cfg_sense_output_select, .status_read, .switch_outputs,
    .fault_status_pin_n, .overcurrent_fault, .overtemp_fault,
    .undervoltage_fault, .short_to_supply_flag, .off_open_load_flag,
    .on_load_missing_flag, .temp_prewarning_flag, .default_inrush_profile,
    .retry_exhausted, .sense_route, .sense_channel, .sense_ratio_high);
  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    begin
      if (bad_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge clk_sys);
      @(negedge clk_sys);
    end
  endtask
  task chk(input [95:0] nm, input [3:0] e, input [3:0] g);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task limit(input integer lim);
    if (k >= lim) begin
      $display("BAD wait exp done got timeout");
      bad_count = bad_count + 1;
      end_sim;
    end
  endtask
  task rd;
    begin
      @(posedge clk_sys) rd_req <= 1'b1;
      @(posedge clk_sys) rd_req <= 1'b0;
      cyc(2);
    end
  endtask
  task wr;
    begin
      @(posedge clk_sys) wr_req <= 1'b1;
      @(posedge clk_sys) wr_req <= 1'b0;
      cyc(2);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_short(input [3:0] dis);
    begin
      @(posedge clk_sys);
      {cfg_short_detect_disable, cfg_off_openload_disable} <= {dis, dis};
      wr;
      @(posedge clk_sys) {short_det, gate_low, off_openload_det} <= 12'h222;
      cyc(2);
      chk("short", 4'h2 & ~dis, short_to_supply_flag);
      chk("offol", 4'h2 & ~dis, off_open_load_flag);
      chk("pin", {3'h0, dis[1]}, {3'h0, fault_status_pin_n});
      rd;
      chk("held", 4'h2 & ~dis, short_to_supply_flag);
      @(posedge clk_sys) {short_det, gate_low, off_openload_det} <= 12'h0;
      rd;
      chk("cleared", 4'h0, short_to_supply_flag | off_open_load_flag);
    end
  endtask
  task t_retry;
    begin
      @(posedge clk_sys) output_command <= 4'h1;
      @(posedge clk_sys) overtemp_det <= 4'h1;
      @(posedge clk_sys) overtemp_det <= 4'h0;
      cyc(1);
      chk("otf", 4'h1, overtemp_fault);
      chk("latched", 4'h0, switch_outputs);
      k = 0;
      seen = 0;
      while (switch_outputs[0] !== 1'b1 && k < 60) begin
        cyc(1);
        k = k + 1;
        seen = seen | default_inrush_profile[0];
      end
      limit(60);
      chk("late", 4'h1, {3'h0, k > 15});
      chk("inrush", 4'h1, seen[3:0]);
      @(posedge clk_sys) overcurrent_det <= 4'h1;
      k = 0;
      while (retry_exhausted[0] !== 1'b1 && k < 900) begin
        cyc(1);
        k = k + 1;
      end
      limit(900);
      chk("sixteen", 4'h1, {3'h0, k > 280});
      chk("ocf", 4'h1, overcurrent_fault);
      cyc(40);
      chk("stays_off", 4'h0, switch_outputs);
      @(posedge clk_sys) {overcurrent_det, cfg_retry_disable} <= 8'h01;
      wr;
      chk("cnt_reset", 4'h0, retry_exhausted);
      @(posedge clk_sys) output_command <= 4'h0;
      @(posedge clk_sys) output_command <= 4'h1;
      cyc(3);
      chk("toggle_on", 4'h1, switch_outputs);
      @(posedge clk_sys) {output_command, cfg_retry_disable} <= 8'h0;
      wr;
      rd;
      chk("prot_clr", 4'h0, overcurrent_fault | overtemp_fault);
    end
  endtask
  task t_on_load_missing_flag;
    begin
      @(posedge clk_sys) {output_command, cfg_led_threshold_select} <= 8'hc8;
      duty_fields <= {7'h7f, 21'h0};
      wr;
      @(posedge clk_sys) {on_low_current_bulb, on_low_current_led} <= 8'hcc;
      cyc(3);
      chk("bulb", 4'h4, on_load_missing_flag);
      chk("still_on", 4'hc, switch_outputs);
      k = 0;
      while (on_load_missing_flag[3] !== 1'b1 && k < 100) begin
        cyc(1);
        k = k + 1;
      end
      limit(100);
      chk("led", 4'h1, {3'h0, k > 20});
      @(posedge clk_sys) {on_low_current_bulb, on_low_current_led} <= 8'h0;
      rd;
      chk("on_load_missing_flag_clr", 4'h0, on_load_missing_flag);
      @(posedge clk_sys) output_command <= 4'h0;
    end
  endtask
  task t_misc;
    begin
      @(posedge clk_sys) output_command <= 4'h2;
      {cfg_sense_enable, cfg_temp_enable} <= 2'b10;
      {cfg_sense_output_select, cfg_sense_ratio_select} <= 6'h12;
      wr;
      chk("route", 4'h2, {1'b0, sense_route});
      chk("chan", 4'h1, {2'h0, sense_channel});
      chk("ratio", 4'h1, {3'h0, sense_ratio_high});
      @(posedge clk_sys) fail_safe_mode <= 1'b1;
      cyc(3);
      chk("fs_route", 4'h0, {3'h0, sense_route[1]});
      @(posedge clk_sys) {fail_safe_mode, cfg_sense_enable} <= 2'b00;
      cfg_temp_enable <= 1'b1;
      wr;
      chk("temp", 4'h1, {1'b0, sense_route});
      @(posedge clk_sys) {clamp_active, output_command} <= 5'h10;
      cyc(2);
      chk("clamp", 4'hf, switch_outputs);
      @(posedge clk_sys) {clamp_active, temp_warning_det} <= 2'b01;
      cyc(2);
      chk("warn", 4'h1, {3'h0, temp_prewarning_flag});
      @(posedge clk_sys) temp_warning_det <= 1'b0;
      rd;
      chk("warn_clr", 4'h0, {3'h0, temp_prewarning_flag});
    end
  endtask
  task t_supply;
    begin
      @(posedge clk_sys) cfg_short_detect_disable <= 4'h8;
      wr;
      @(posedge clk_sys) {logic_supply_ok, direct_inputs} <= 5'h0a;
      cyc(3);
      chk("direct", 4'ha, switch_outputs);
      @(posedge clk_sys) {logic_supply_ok, direct_inputs} <= 5'h10;
      cyc(2);
      @(posedge clk_sys) {short_det, gate_low} <= 8'h88;
      cyc(3);
      chk("cfg_wiped", 4'h8, short_to_supply_flag);
      @(posedge clk_sys) battery_ok <= 1'b0;
      cyc(3);
      chk("uv", 4'h1, {3'h0, undervoltage_fault});
      @(posedge clk_sys) {battery_ok, short_det, gate_low} <= 9'h100;
      por_both_low <= 1'b1;
      cyc(2);
      chk("por", 4'h0, short_to_supply_flag);
      chk("por_uv", 4'h0, {3'h0, undervoltage_fault});
      @(posedge clk_sys) por_both_low <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    cyc(2);
    t_short(4'h0);
    t_short(4'h2);
    t_short(4'h0);
    t_retry;
    t_on_load_missing_flag;
    t_misc;
    t_supply;
    end_sim;
  end
endmodule // test_fault_autoretry_diagnostics
